// [design/lbh_agent.sv]
// outside agent end: memory responder, strap driver and external master
// assumes the device end shares ref_clk and rst_n
`timescale 1ns/1ps
`default_nettype none
`include "lbh_params.svh"
module lbh_agent (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // link
   lbh_if.agt bus,
   // user side
   input wire logic boot_master_strap,
   input wire logic hold_want,
   input wire logic [1:0] ready_delay,
   input wire logic fail_next,
   output logic hold_owned,
   output logic [1:0] low_addr_q,
   output logic sel_bad_q
);
   logic [1:0] wait_q, wait_d;
   logic busy_q, busy_d;
   logic bad_q, bad_d;
   logic [1:0] la_d;
   logic sb_d;
   logic rdy;
   logic [31:0] addr_q, addr_d;

   // ready only while the device still drives a data state
   assign rdy = busy_q && (wait_q == 2'h0) && bus.byte_lane_selects_oe;
   assign bus.ready_n = ~rdy;
   // read data is the inverted address, so lanes can be told apart
   assign bus.muxed_addr_data_ext = ~addr_q;
   assign bus.bus_request = hold_want;
   // strap while reset; bad access only once the device has gone idle,
   // which is the cycle after the last ready
   assign bus.bad_access_in = rst_n ? (bad_q && !bus.byte_lane_selects_oe)
      : boot_master_strap;
   assign bus.message_or_irq0_input_n = 1'b1;
   // only drive after the grant is seen
   assign hold_owned = bus.bus_grant_out && bus.bus_grant_oe;

   always_comb begin
      busy_d = busy_q;
      wait_d = wait_q;
      bad_d = 1'b0;
      la_d = low_addr_q;
      sb_d = sel_bad_q;
      addr_d = addr_q;
      if (!bus.address_status_strobe_n && !busy_q) begin
         busy_d = 1'b1;
         wait_d = ready_delay;
         addr_d = bus.muxed_addr_data_o;
         la_d = lbh_pkg::lbh_low_addr(bus.byte_lane_selects_n);
         sb_d = !lbh_pkg::lbh_sel_ok(bus.byte_lane_selects_n);
      end else if (busy_q && !bus.byte_lane_selects_oe) begin
         // device went idle after its last ready
         busy_d = 1'b0;
      end else if (rdy) begin
         // every ready closes one word; selects seen mid-burst not trusted
         wait_d = ready_delay;
         bad_d = fail_next;
      end else if (busy_q) begin
         wait_d = wait_q - 2'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         wait_q <= 2'h0;
         bad_q <= 1'b0;
         low_addr_q <= 2'h0;
         sel_bad_q <= 1'b0;
         addr_q <= 32'h0;
      end else if (clk_en) begin
         busy_q <= busy_d;
         wait_q <= wait_d;
         bad_q <= bad_d;
         low_addr_q <= la_d;
         sel_bad_q <= sb_d;
         addr_q <= addr_d;
      end
   end
endmodule // lbh_agent
`default_nettype wire

// [design/lbh_device.sv]
// processor end: lane selects, hold arbitration, cache flag, reset strap
// assumes rst_n is held at least 41 clocks and released after an edge
`timescale 1ns/1ps
`default_nettype none
`include "lbh_params.svh"
// What this block does
// - four low-active lane selects, top is bits 31:24
// - address state selects give first word bytes
// - data state selects give next word bytes
// - outside treats early data-state selects undefined
// - selects latched, steady while ready absent
// - read selects mark exactly consumed bytes
// - selects contiguous, at least one asserted
// - outside decodes low address from selects
// - grant floats bus, asserts grant, held state
// - request removed: drop grant, idle or address
// - outside master waits for grant before driving
// - cacheable flag driven in address state
// - never cacheable on synchronous accesses
// - cacheable flag floats while bus idle
// - bad access after last ready is fatal
// - bad access sampled as boot strap in reset
// - reset clears logic, ignores most inputs
// - reset floats three-states, deasserts others
// - reset held at least 41 clocks
// - reset released just after clock edges
// - no ready in data state inserts wait
// - message input held high during reset
module lbh_device (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // link
   lbh_if.dev bus,
   // request stream in
   input wire logic req_valid,
   output logic req_ready,
   input wire lbh_pkg::lbh_req_s req_in,
   input wire logic [1:0] req_words,
   // status out
   output logic done_pulse,
   output logic bus_error_q,
   output logic boot_master_q,
   output logic irq0_strap_ok_q,
   output logic [31:0] read_data_q,
   output logic granted
);
   // two-entry buffer in the request path
   lbh_pkg::lbh_req_s buf_q [`LBH_BUF_DEPTH];
   logic [1:0] bw_q [`LBH_BUF_DEPTH];
   logic wp_q, wp_d, rp_q, rp_d;
   logic [1:0] cnt_q, cnt_d;
   logic pop;
   lbh_pkg::lbh_req_s cur_q, cur_d;
   logic [1:0] left_q, left_d;
   lbh_pkg::lbh_state_e st_q, st_d;
   logic err_pend_q, err_pend_d;
   logic err_d, boot_d, irq_d;
   logic [31:0] rd_d;
   logic rdy;

   assign req_ready = cnt_q != 2'h2;
   assign rdy = !bus.ready_n;
   // only take between transactions
   assign pop = (cnt_q != 2'h0) && !bus.bus_request &&
      ((st_q == lbh_pkg::LBH_IDLE) || (st_q == lbh_pkg::LBH_HELD));

   always_comb begin
      wp_d = wp_q;
      rp_d = rp_q;
      cnt_d = cnt_q;
      if (req_valid && req_ready) begin
         wp_d = ~wp_q;
         cnt_d = cnt_d + 2'h1;
      end
      if (pop) begin
         rp_d = ~rp_q;
         cnt_d = cnt_d - 2'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clk_en && req_valid && req_ready) begin
         buf_q[wp_q] <= req_in;
         bw_q[wp_q] <= req_words;
      end
   end

   // ****************************************************
   // bus state
   // ****************************************************
   always_comb begin
      st_d = st_q;
      cur_d = cur_q;
      left_d = left_q;
      err_pend_d = 1'b0;
      err_d = bus_error_q;
      rd_d = read_data_q;
      done_pulse = 1'b0;
      if (err_pend_q && bus.bad_access_in) begin
         err_d = 1'b1;
      end
      unique case (st_q)
         lbh_pkg::LBH_IDLE, lbh_pkg::LBH_HELD: begin
            if (bus.bus_request) begin
               st_d = lbh_pkg::LBH_HELD;
            end else if (pop) begin
               cur_d = buf_q[rp_q];
               left_d = bw_q[rp_q];
               st_d = lbh_pkg::LBH_ADDR;
            end else begin
               st_d = lbh_pkg::LBH_IDLE;
            end
         end
         lbh_pkg::LBH_ADDR: st_d = lbh_pkg::LBH_DATA;
         lbh_pkg::LBH_DATA, lbh_pkg::LBH_WAIT: begin
            if (!rdy) begin
               st_d = lbh_pkg::LBH_WAIT;
            end else begin
               if (!cur_q.write) begin
                  // keep only the lanes that were selected
                  for (int i = 0; i < `LBH_LANES; i++) begin
                     if (!cur_q.sel_n[i]) begin
                        rd_d[i*8 +: 8] = bus.muxed_addr_data_ext[i*8 +: 8];
                     end
                  end
               end
               if (left_q == 2'h0) begin
                  st_d = lbh_pkg::LBH_IDLE;
                  err_pend_d = 1'b1;
                  done_pulse = 1'b1;
               end else begin
                  left_d = left_q - 2'h1;
                  st_d = lbh_pkg::LBH_DATA;
               end
            end
         end
      endcase
   end

   // strap and message input are the only link inputs looked at in reset
   always_comb begin
      boot_d = boot_master_q;
      irq_d = irq0_strap_ok_q;
      // the strap is only valid while reset is low
      if (!rst_n) begin
         boot_d = bus.bad_access_in;
         irq_d = bus.message_or_irq0_input_n;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
         st_q <= lbh_pkg::LBH_IDLE;
         cur_q <= '0;
         left_q <= 2'h0;
         err_pend_q <= 1'b0;
         bus_error_q <= 1'b0;
         read_data_q <= 32'h0;
      end else if (clk_en) begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         st_q <= st_d;
         cur_q <= cur_d;
         left_q <= left_d;
         err_pend_q <= err_pend_d;
         bus_error_q <= err_d;
         read_data_q <= rd_d;
      end
   end

   // strap kept from the last edge seen while reset is low
   always_ff @(posedge ref_clk) begin
      if (clk_en) begin
         boot_master_q <= boot_d;
         irq0_strap_ok_q <= irq_d;
      end
   end

   // ****************************************************
   // pins
   // ****************************************************
   logic active;
   assign active = rst_n && (st_q != lbh_pkg::LBH_IDLE) &&
      (st_q != lbh_pkg::LBH_HELD);
   // latched selects, steady through waits
   assign bus.byte_lane_selects_n = active ? cur_q.sel_n
      : `LBH_SEL_IDLE;
   assign bus.byte_lane_selects_oe = active;
   assign bus.muxed_addr_data_o = (st_q == lbh_pkg::LBH_ADDR) ? cur_q.addr
      : 32'h0;
   assign bus.muxed_addr_data_oe = active &&
      ((st_q == lbh_pkg::LBH_ADDR) || cur_q.write);
   assign bus.address_status_strobe_n = !(rst_n &&
      (st_q == lbh_pkg::LBH_ADDR));
   assign bus.write_n_read = active && cur_q.write;
   assign bus.cacheable = (st_q == lbh_pkg::LBH_ADDR) &&
      cur_q.cacheable && !cur_q.sync_acc;
   assign bus.cacheable_oe = active;
   assign bus.bus_grant_out = rst_n && (st_q == lbh_pkg::LBH_HELD);
   assign bus.bus_grant_oe = rst_n;
   assign granted = bus.bus_grant_out;
endmodule // lbh_device
`default_nettype wire

// [inc/lbh_if.sv]
// local bus pins between the processor end and the outside agent
// assumes the testbench resolves three-state lines from the enables
`timescale 1ns/1ps
`default_nettype none
interface lbh_if;
   logic [3:0] byte_lane_selects_n;
   logic byte_lane_selects_oe;
   logic [31:0] muxed_addr_data_o;
   logic muxed_addr_data_oe;
   logic [31:0] muxed_addr_data_ext;
   logic address_status_strobe_n;
   logic write_n_read;
   logic ready_n;
   logic cacheable;
   logic cacheable_oe;
   logic bus_request;
   logic bus_grant_out;
   logic bus_grant_oe;
   logic bad_access_in;
   logic message_or_irq0_input_n;
   modport dev (
      output byte_lane_selects_n, byte_lane_selects_oe, muxed_addr_data_o,
      output muxed_addr_data_oe, address_status_strobe_n, write_n_read,
      output cacheable, cacheable_oe, bus_grant_out, bus_grant_oe,
      input muxed_addr_data_ext, ready_n, bus_request, bad_access_in,
      input message_or_irq0_input_n
   );
   modport agt (
      input byte_lane_selects_n, byte_lane_selects_oe, muxed_addr_data_o,
      input muxed_addr_data_oe, address_status_strobe_n, write_n_read,
      input cacheable, cacheable_oe, bus_grant_out, bus_grant_oe,
      output muxed_addr_data_ext, ready_n, bus_request, bad_access_in,
      output message_or_irq0_input_n
   );
endinterface
`default_nettype wire

// [inc/lbh_params.svh]
// timing counts and field positions for the lane select and hold control
// assumes inclusion by bare name from package and design files
`ifndef LBH_PARAMS_SVH
`define LBH_PARAMS_SVH
`define LBH_LANES 4
`define LBH_SEL_IDLE 4'hf
`define LBH_CLK_NS 100
`define LBH_RST_MIN_CYC 41
`define LBH_BUF_DEPTH 2
`endif

// [inc/lbh_pkg.sv]
// types shared by both ends of the local bus lane and hold link
// assumes lbh_params.svh sits on the include path
`default_nettype none
`include "lbh_params.svh"
package lbh_pkg;
   typedef logic [`LBH_LANES-1:0] lbh_sel_t;
   typedef logic [31:0] lbh_word_t;
   typedef enum logic [2:0] {
      LBH_IDLE, LBH_ADDR, LBH_DATA, LBH_WAIT, LBH_HELD
   } lbh_state_e;
   typedef struct packed {
      lbh_word_t addr;
      lbh_sel_t sel_n;
      logic write;
      logic cacheable;
      logic sync_acc;
   } lbh_req_s;
   // contiguous non-empty active-low lane pattern
   function automatic logic lbh_sel_ok(input lbh_sel_t s_n);
      logic [3:0] a;
      a = ~s_n;
      return (a == 4'h1) || (a == 4'h2) || (a == 4'h4) || (a == 4'h8) ||
         (a == 4'h3) || (a == 4'h6) || (a == 4'hc) || (a == 4'h7) ||
         (a == 4'he) || (a == 4'hf);
   endfunction
   // low address bits recovered from the lowest selected lane
   function automatic logic [1:0] lbh_low_addr(input lbh_sel_t s_n);
      return (!s_n[0]) ? 2'h0 : (!s_n[1]) ? 2'h1 : (!s_n[2]) ? 2'h2 : 2'h3;
   endfunction
endpackage
`default_nettype wire

// [sim/lbh_link_monitor.sv]
// assertions on the lane select and hold link
// assumes the bench wires the interface signals in by name
`timescale 1ns/1ps
`default_nettype none
module lbh_link_monitor (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // link
   input wire logic [3:0] byte_lane_selects_n,
   input wire logic byte_lane_selects_oe,
   input wire logic muxed_addr_data_oe,
   input wire logic address_status_strobe_n,
   input wire logic ready_n,
   input wire logic cacheable,
   input wire logic cacheable_oe,
   input wire logic bus_request,
   input wire logic bus_grant_out
);
   // ****
   // checks
   // ****
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [3:0] act;
   logic [3:0] low;
   logic dwait;
   assign act = ~byte_lane_selects_n;
   assign low = act & (~act + 4'h1);
   assign dwait = byte_lane_selects_oe && address_status_strobe_n && ready_n;
   AST_RESET_PARK: assert property ($rose(rst_n) |->
      byte_lane_selects_n == 4'hf && !byte_lane_selects_oe &&
      address_status_strobe_n && !bus_grant_out && !cacheable_oe)
      else $error("outputs not parked after reset");
   AST_SEL_CONTIG: assert property (byte_lane_selects_oe |->
      act != 4'h0 && ((act + low) & act) == 4'h0)
      else $error("lane selects empty or split");
   AST_SEL_HOLD: assert property (dwait |=>
      $stable(byte_lane_selects_n)) else $error("selects moved in wait");
   AST_WAIT_NO_STROBE: assert property (dwait |=>
      address_status_strobe_n && byte_lane_selects_oe)
      else $error("wait state missing or strobe raised");
   AST_STROBE_ONE: assert property (!address_status_strobe_n |=>
      address_status_strobe_n && byte_lane_selects_oe)
      else $error("strobe longer than one cycle");
   AST_CACHE_ADDR: assert property (!address_status_strobe_n |->
      cacheable_oe && muxed_addr_data_oe) else $error("cache flag undriven");
   AST_CACHE_ONLY_ADDR: assert property (cacheable |->
      !address_status_strobe_n && cacheable_oe)
      else $error("cache flag outside address state");
   AST_CACHE_IDLE: assert property (!byte_lane_selects_oe |->
      !cacheable_oe) else $error("cache flag driven while idle");
   AST_GRANT_FLOAT: assert property (bus_grant_out |->
      !byte_lane_selects_oe && !muxed_addr_data_oe && !cacheable_oe &&
      address_status_strobe_n) else $error("bus driven while granted");
   AST_GRANT_CAUSE: assert property ($rose(bus_grant_out) |->
      $past(bus_request) && !$past(byte_lane_selects_oe))
      else $error("grant without request or mid transfer");
   AST_GRANT_DROP: assert property ($fell(bus_request) |->
      ##[0:2] !bus_grant_out) else $error("grant kept after request");
endmodule // lbh_link_monitor
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench joining the device end and the agent end
// assumes the package, interface and params header are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "lbh_params.svh"
module testbench;
   // ****
   // stimulus and checks
   // ****
   localparam logic [3:0] PATS [10] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc,
      4'h9, 4'h3, 4'h8, 4'h1, 4'h0};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b1;
   logic req_valid = 1'b0;
   lbh_pkg::lbh_req_s req_in = '0;
   logic [1:0] req_words = 2'h0;
   logic strap = 1'b0;
   logic hold_want = 1'b0;
   logic fail_next = 1'b0;
   logic [1:0] ready_delay = 2'h0;
   logic req_ready, done_pulse, bus_error_q, boot_master_q, irq0_ok;
   logic granted, hold_owned, sel_bad_q, err_exp;
   logic [31:0] read_data_q;
   logic [31:0] rd_model = 32'h0;
   logic [1:0] low_addr_q;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int dones = 0;
   lbh_if bus_if ();
   always #(`LBH_CLK_NS / 2) ref_clk = ~ref_clk;
   lbh_device u_lbh_device (.ref_clk(ref_clk), .rst_n(rst_n),
      .clk_en(1'b1), .bus(bus_if), .req_valid(req_valid),
      .req_ready(req_ready), .req_in(req_in), .req_words(req_words),
      .done_pulse(done_pulse), .bus_error_q(bus_error_q),
      .boot_master_q(boot_master_q), .irq0_strap_ok_q(irq0_ok),
      .read_data_q(read_data_q), .granted(granted));
   lbh_agent u_lbh_agent (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
      .bus(bus_if), .boot_master_strap(strap), .hold_want(hold_want),
      .ready_delay(ready_delay), .fail_next(fail_next),
      .hold_owned(hold_owned), .low_addr_q(low_addr_q),
      .sel_bad_q(sel_bad_q));
   lbh_link_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n),
      .byte_lane_selects_n(bus_if.byte_lane_selects_n),
      .byte_lane_selects_oe(bus_if.byte_lane_selects_oe),
      .muxed_addr_data_oe(bus_if.muxed_addr_data_oe),
      .address_status_strobe_n(bus_if.address_status_strobe_n),
      .ready_n(bus_if.ready_n), .cacheable(bus_if.cacheable),
      .cacheable_oe(bus_if.cacheable_oe),
      .bus_request(bus_if.bus_request),
      .bus_grant_out(bus_if.bus_grant_out));
   task automatic print_verdict;
      if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (done_pulse === 1'b1) dones <= dones + 1;
      if (cyc == 20000) begin
         err_count++;
         print_verdict();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [1:0] exp_low(input logic [3:0] s);
      exp_low = 2'h3;
      for (int i = 3; i >= 0; i--) if (!s[i]) exp_low = 2'(i);
   endfunction
   // agent returns the inverted address; only selected lanes are taken
   function automatic logic [31:0] exp_read(input logic [31:0] old,
      input logic [31:0] a, input logic [3:0] s);
      exp_read = old;
      for (int i = 0; i < 4; i++) if (!s[i]) exp_read[i*8 +: 8] = ~a[i*8 +: 8];
   endfunction
   task automatic do_reset(input logic s);
      rst_n <= 1'b0;
      strap <= s;
      hold_want <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check("grant in reset", bus_if.bus_grant_out, 1'b0);
      hold_want <= 1'b0;
      repeat (`LBH_RST_MIN_CYC) @(posedge ref_clk);
      rst_n <= 1'b1;
      err_exp = 1'b0;
      rd_model = 32'h0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check("boot strap", boot_master_q, s);
      check("message strap", irq0_ok, 1'b1);
      check("error after reset", bus_error_q, 1'b0);
      @(posedge ref_clk);
   endtask
   task automatic xfer(input logic fail);
      lbh_pkg::lbh_req_s r;
      int t;
      int k;
      r.addr = $urandom();
      r.sel_n = PATS[$urandom_range(9)];
      r.write = 1'($urandom_range(1));
      r.cacheable = 1'($urandom_range(1));
      r.sync_acc = 1'($urandom_range(1));
      t = dones;
      k = 0;
      err_exp = err_exp | fail;
      ready_delay <= 2'($urandom_range(3));
      fail_next <= fail;
      req_valid <= 1'b1;
      req_in <= r;
      req_words <= 2'($urandom_range(3));
      do @(negedge ref_clk); while (req_ready !== 1'b1);
      @(posedge ref_clk);
      req_valid <= 1'b0;
      while (bus_if.address_status_strobe_n !== 1'b0 && k++ < 40)
         @(negedge ref_clk);
      check("strobe", bus_if.address_status_strobe_n, 1'b0);
      check("selects", bus_if.byte_lane_selects_n, r.sel_n);
      check("address", bus_if.muxed_addr_data_o, r.addr);
      check("direction", bus_if.write_n_read, r.write);
      check("cache", bus_if.cacheable, r.cacheable & ~r.sync_acc);
      while (dones == t && k++ < 100) @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      check("done", dones, t + 1);
      check("bus error", bus_error_q, err_exp);
      check("low address", low_addr_q, exp_low(r.sel_n));
      check("select shape", sel_bad_q, 1'b0);
      if (!r.write) rd_model = exp_read(rd_model, r.addr, r.sel_n);
      check("read data", read_data_q, rd_model);
      @(posedge ref_clk);
   endtask
   initial begin
      int t;
      void'($urandom(10577));
      do_reset(1'b0);
      repeat (30) xfer(1'b0);
      xfer(1'b1);
      xfer(1'b0);
      hold_want <= 1'b1;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      check("granted", granted, 1'b1);
      check("agent owns", hold_owned, 1'b1);
      @(posedge ref_clk);
      t = dones;
      req_valid <= 1'b1;
      req_in <= '{32'h0000_0040, 4'h0, 1'b1, 1'b0, 1'b0};
      req_words <= 2'h0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check("buffer full", req_ready, 1'b0);
      @(posedge ref_clk);
      req_valid <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check("held, no transfer", dones, t);
      hold_want <= 1'b0;
      repeat (40) @(posedge ref_clk);
      check("buffer drained", dones, t + 2);
      do_reset(1'b1);
      repeat (10) xfer(1'b0);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
